// ### logic/osp_top.sv
// command core for the otp security pages and the unique identifier
`timescale 1ns/100ps
module osp_top
  import osp_pkg::*;
#(
  parameter int          PROG_CYCLES = PROG_CYC,
  parameter logic [63:0] UID_VALUE   = UID_DEFAULT
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_spi_sck,
  input  wire logic       i_spi_cs_n,
  input  wire logic       i_spi_si,
  input  wire logic [2:0] i_lock_set,
  output logic            o_spi_so,
  output logic            o_spi_so_oe,
  output logic            o_ready_busy_flag,
  output logic            o_write_enable_latch,
  output logic [2:0]      o_page_lock_bits
);
  localparam int TW = $clog2(PROG_CYCLES + 1);
  localparam int MW = $clog2(PAGE_COUNT * PAGE_BYTES);

  osp_link_if lnk ();

  osp_link u_link (
    .i_rst       (i_rst),
    .i_spi_sck   (i_spi_sck),
    .i_spi_cs_n  (i_spi_cs_n),
    .i_spi_si    (i_spi_si),
    .o_spi_so    (o_spi_so),
    .o_spi_so_oe (o_spi_so_oe),
    .lnk         (lnk.link)
  );

  osp_state_t      st_reg;
  logic            cs_s1_reg;
  logic            cs_s2_reg;
  logic            cs_d_reg;
  logic            tg_s1_reg;
  logic            tg_s2_reg;
  logic            tg_d_reg;
  logic            pt_s1_reg;
  logic            pt_s2_reg;
  logic            byte_evt;
  logic            frame_end;
  logic [4:0]      cnt_reg;
  logic [7:0]      opc_reg;
  logic [23:0]     addr_reg;
  logic [23:0]     addr_now;
  logic [1:0]      ptr_pg_reg;
  logic            ptr_ok_reg;
  logic [7:0]      ptr_off_reg;
  logic [63:0]     uid_sh_reg;
  logic            wen_reg;
  logic [2:0]      lock_reg;
  logic [1:0]      op_pg_reg;
  logic [TW-1:0]   timer_reg;
  logic [255:0]    mask_reg;
  logic [MW-1:0]   rd_idx;
  logic            rd_ok;
  logic [7:0]      rd_data;
  logic            in_data;
  logic [7:0]      mem [0:PAGE_COUNT*PAGE_BYTES-1];
  logic [7:0]      page_buf [0:PAGE_BYTES-1];

  function automatic logic page_hit(input logic [23:0] a);
    page_hit = (a[23:16] == PAGE_TOP) && (a[11:8] == PAGE_NIB_LO) &&
               (a[15:12] >= PAGE_FIRST) && (a[15:12] <= PAGE_LAST);
  endfunction : page_hit

  // page number minus one, valid only when page_hit holds
  function automatic logic [1:0] page_sel(input logic [23:0] a);
    page_sel = a[13:12] - 2'h1;
  endfunction : page_sel

  // pin-side levels enter through two flip-flops; a third stage on select
  // lets the last byte event land before the frame end is seen
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_d_reg  <= 1'b1;
    end else begin
      cs_s1_reg <= i_spi_cs_n;
      cs_s2_reg <= cs_s1_reg;
      cs_d_reg  <= cs_s2_reg;
    end
  end

  // byte toggle and boundary flag crossing
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tg_s1_reg <= 1'b0;
      tg_s2_reg <= 1'b0;
      tg_d_reg  <= 1'b0;
      pt_s1_reg <= 1'b0;
      pt_s2_reg <= 1'b0;
    end else begin
      tg_s1_reg <= lnk.rx_tgl;
      tg_s2_reg <= tg_s1_reg;
      tg_d_reg  <= tg_s2_reg;
      pt_s1_reg <= lnk.partial;
      pt_s2_reg <= pt_s1_reg;
    end
  end

  assign byte_evt  = tg_s2_reg ^ tg_d_reg;
  assign frame_end = cs_s2_reg & ~cs_d_reg;
  assign addr_now  = {addr_reg[15:0], lnk.rx_byte};
  assign in_data   = cnt_reg > IDX_ADDR_LAST;

  // byte index within the frame, saturating
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || frame_end) begin
      cnt_reg <= IDX_OPC;
    end else if (byte_evt && cnt_reg != CNT_SAT) begin
      cnt_reg <= cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      opc_reg  <= IDLE_BYTE;
      addr_reg <= 24'h00_0000;
    end else if (byte_evt) begin
      if (cnt_reg == IDX_OPC) begin
        opc_reg <= lnk.rx_byte;
      end else if (cnt_reg <= IDX_ADDR_LAST) begin
        addr_reg <= addr_now;
      end
    end
  end

  // pointer set from the start address
  // 8-bit offset rolls over inside the page with no extra cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ptr_pg_reg  <= 2'h0;
      ptr_ok_reg  <= 1'b0;
      ptr_off_reg <= 8'h00;
    end else if (byte_evt) begin
      if (cnt_reg == IDX_ADDR_LAST) begin
        ptr_pg_reg  <= page_sel(addr_now);
        ptr_ok_reg  <= page_hit(addr_now);
        ptr_off_reg <= (opc_reg == OP_READ) ? addr_now[7:0] + 8'h01 : addr_now[7:0];
      end else if (in_data && (opc_reg == OP_READ || opc_reg == OP_PROG)) begin
        ptr_off_reg <= ptr_off_reg + 8'h01;
      end
    end
  end

  // read port: the first byte comes straight from the fresh address
  always_comb begin
    if (cnt_reg == IDX_ADDR_LAST) begin
      rd_idx = {page_sel(addr_now), addr_now[7:0]};
      rd_ok  = page_hit(addr_now);
    end else begin
      rd_idx = {ptr_pg_reg, ptr_off_reg};
      rd_ok  = ptr_ok_reg;
    end
  end

  // unmapped addresses read as erased
  assign rd_data = rd_ok ? mem[rd_idx] : ERASED_BYTE;

  // identifier shifter, loaded as each new opcode arrives
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      uid_sh_reg <= UID_VALUE;
    end else if (byte_evt) begin
      if (cnt_reg == IDX_OPC) begin
        uid_sh_reg <= UID_VALUE;
      end else if (opc_reg == OP_UID && cnt_reg >= UID_FIRST - FEED_LEAD) begin
        uid_sh_reg <= {uid_sh_reg[UID_BITS-9:0], IDLE_BYTE};
      end
    end
  end

  // transmit feed: a byte handed over after byte k shifts out as byte k+2,
  // which leaves the shifter a full byte time to pick it up safely
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || frame_end) begin
      lnk.tx_byte  <= IDLE_BYTE;
      lnk.tx_valid <= 1'b0;
    end else if (byte_evt && st_reg == ST_READY) begin
      case (opc_reg)
        OP_READ: begin
          if (cnt_reg >= READ_FIRST - FEED_LEAD) begin
            lnk.tx_byte  <= rd_data;
            lnk.tx_valid <= 1'b1;
          end
        end
        OP_UID: begin
          if (cnt_reg >= UID_FIRST - FEED_LEAD &&
              cnt_reg < UID_FIRST - FEED_LEAD + UID_BYTES) begin
            lnk.tx_byte  <= uid_sh_reg[UID_BITS-1 -: 8];
            lnk.tx_valid <= 1'b1;
          end else begin
            lnk.tx_valid <= 1'b0;
          end
        end
        default: begin
          lnk.tx_valid <= 1'b0;
        end
      endcase
    end
  end

  // program data lands in the shared buffer
  always_ff @(posedge i_sys_clk) begin
    if (byte_evt && st_reg == ST_READY && opc_reg == OP_PROG && in_data) begin
      page_buf[ptr_off_reg] <= lnk.rx_byte;
    end
  end

  // loaded-byte mask, so unsent offsets keep their contents
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      mask_reg <= '0;
    end else if (byte_evt && st_reg == ST_READY) begin
      if (cnt_reg == IDX_OPC) begin
        mask_reg <= '0;
      end else if (opc_reg == OP_PROG && in_data) begin
        mask_reg[ptr_off_reg] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      lock_reg <= LOCK_RST;
    end else begin
      lock_reg <= lock_reg | i_lock_set;
    end
  end

  // command acceptance at frame end and the self-timed operation
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_reg    <= ST_READY;
      wen_reg   <= LATCH_RST;
      op_pg_reg <= 2'h0;
      timer_reg <= '0;
    end else begin
      case (st_reg)
        ST_READY: begin
          if (frame_end && cnt_reg != IDX_OPC) begin
            case (opc_reg)
              // aligned whole opcode sets the latch
              OP_WREN: begin
                if (!pt_s2_reg) begin
                  wen_reg <= 1'b1;
                end
              end
              OP_WRDI: begin
                if (!pt_s2_reg) begin
                  wen_reg <= 1'b0;
                end
              end
              OP_ERASE: begin
                if (wen_reg) begin
                  if (cnt_reg != ERASE_LEN || pt_s2_reg) begin
                    wen_reg <= 1'b0;
                  end else if (!page_hit(addr_reg) || lock_reg[page_sel(addr_reg)]) begin
                    wen_reg <= 1'b0;
                  end else begin
                    op_pg_reg <= page_sel(addr_reg);
                    timer_reg <= '0;
                    st_reg    <= ST_ERASE;
                  end
                end
              end
              OP_PROG: begin
                if (wen_reg) begin
                  // aligned release with data starts program
                  if (cnt_reg < PROG_MIN_LEN || pt_s2_reg) begin
                    wen_reg <= 1'b0;
                  end else if (!page_hit(addr_reg) || lock_reg[page_sel(addr_reg)]) begin
                    wen_reg <= 1'b0;
                  end else begin
                    op_pg_reg <= page_sel(addr_reg);
                    timer_reg <= '0;
                    st_reg    <= ST_PROG;
                  end
                end
              end
              default: begin
              end
            endcase
          end
        end
        ST_ERASE, ST_PROG: begin
          if (timer_reg == TW'(PROG_CYCLES - 1)) begin
            st_reg  <= ST_READY;
            wen_reg <= 1'b0;
          end else begin
            timer_reg <= timer_reg + 1'b1;
          end
        end
        default: begin
          st_reg <= ST_READY;
        end
      endcase
    end
  end

  // page update walks one byte per cycle early in the operation;
  // programming can only clear bits, as on real cells
  always_ff @(posedge i_sys_clk) begin
    if (st_reg != ST_READY && timer_reg < TW'(PAGE_BYTES)) begin
      if (st_reg == ST_ERASE) begin
        mem[{op_pg_reg, timer_reg[7:0]}] <= ERASED_BYTE;
      end else if (mask_reg[timer_reg[7:0]]) begin
        mem[{op_pg_reg, timer_reg[7:0]}] <= mem[{op_pg_reg, timer_reg[7:0]}] &
                                            page_buf[timer_reg[7:0]];
      end
    end
  end

  assign o_ready_busy_flag    = (st_reg != ST_READY);
  assign o_write_enable_latch = wen_reg;
  assign o_page_lock_bits     = lock_reg;
endmodule : osp_top

// ### common/osp_pkg.sv
// shared constants and types for the otp security page access block
package osp_pkg;
  // opcodes
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_UID   = 8'h4b;
  localparam logic [7:0] OP_ERASE = 8'h44;
  localparam logic [7:0] OP_PROG  = 8'h42;
  localparam logic [7:0] OP_READ  = 8'h48;
  // byte positions within a frame, opcode is byte 0
  localparam logic [4:0] IDX_OPC       = 5'h00;
  localparam logic [4:0] IDX_ADDR_LAST = 5'h03;
  localparam logic [4:0] FEED_LEAD     = 5'h02;
  localparam logic [4:0] READ_FIRST    = 5'h05;
  localparam logic [4:0] UID_FIRST     = 5'h05;
  localparam logic [4:0] UID_BYTES     = 5'h08;
  localparam logic [4:0] ERASE_LEN     = 5'h04;
  localparam logic [4:0] PROG_MIN_LEN  = 5'h05;
  localparam logic [4:0] CNT_SAT       = 5'h1f;
  // page address decode
  localparam logic [7:0] PAGE_TOP    = 8'h00;
  localparam logic [3:0] PAGE_NIB_LO = 4'h0;
  localparam logic [3:0] PAGE_FIRST  = 4'h1;
  localparam logic [3:0] PAGE_LAST   = 4'h3;
  localparam int         PAGE_BYTES  = 256;
  localparam int         PAGE_COUNT  = 3;
  localparam int         UID_BITS    = 64;
  // data and reset values
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] IDLE_BYTE   = 8'h00;
  localparam logic       LATCH_RST   = 1'b0;
  localparam logic [2:0] LOCK_RST    = 3'h0;
  // self-timed operation length
  localparam int PROG_TIME_US = 1000;
  localparam int SYS_CLK_MHZ  = 125;
  localparam int PROG_CYC     = PROG_TIME_US * SYS_CLK_MHZ;
  // arbitrary identifier value
  localparam logic [63:0] UID_DEFAULT = 64'h0123_4567_89ab_cdef;

  typedef enum logic [1:0] {ST_READY, ST_ERASE, ST_PROG} osp_state_t;
endpackage : osp_pkg

// ### common/osp_link_if.sv
// byte carrier between the serial shifter and the command core
`timescale 1ns/100ps
interface osp_link_if;
  logic [7:0] rx_byte;
  logic       rx_tgl;
  logic       partial;
  logic [7:0] tx_byte;
  logic       tx_valid;

  modport link (output rx_byte, output rx_tgl, output partial,
                input tx_byte, input tx_valid);
  modport core (input rx_byte, input rx_tgl, input partial,
                output tx_byte, output tx_valid);
endinterface : osp_link_if

// ### logic/osp_link.sv
// serial shifter running on the host serial clock
`timescale 1ns/100ps
module osp_link
  import osp_pkg::*;
(
  input  wire logic i_rst,
  input  wire logic i_spi_sck,
  input  wire logic i_spi_cs_n,
  input  wire logic i_spi_si,
  output logic      o_spi_so,
  output logic      o_spi_so_oe,
  osp_link_if.link  lnk
);
  logic [2:0] bit_cnt_reg;
  logic [6:0] rx_sh_reg;
  logic [7:0] tx_sh_reg;
  logic       oe_reg;

  // bit counter, cleared while deselected
  always_ff @(posedge i_spi_sck or posedge i_spi_cs_n) begin
    if (i_spi_cs_n) begin
      bit_cnt_reg <= 3'h0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  // input shift, msb first on rising edges
  always_ff @(posedge i_spi_sck) begin
    rx_sh_reg <= {rx_sh_reg[5:0], i_spi_si};
    if (bit_cnt_reg == 3'h7) begin
      lnk.rx_byte <= {rx_sh_reg, i_spi_si};
    end
  end

  // byte event toggle and boundary flag; both hold once the clock stops
  always_ff @(posedge i_spi_sck or posedge i_rst) begin
    if (i_rst) begin
      lnk.rx_tgl  <= 1'b0;
      lnk.partial <= 1'b0;
    end else begin
      lnk.partial <= (bit_cnt_reg != 3'h7);
      if (bit_cnt_reg == 3'h7) begin
        lnk.rx_tgl <= ~lnk.rx_tgl;
      end
    end
  end

  // output shift on falling edges, new byte at each boundary
  // tx word is stable here: the core only changes it well after this edge
  always_ff @(negedge i_spi_sck or posedge i_spi_cs_n) begin
    if (i_spi_cs_n) begin
      tx_sh_reg <= IDLE_BYTE;
      oe_reg    <= 1'b0;
    end else if (bit_cnt_reg == 3'h0) begin
      tx_sh_reg <= lnk.tx_byte;
      oe_reg    <= lnk.tx_valid;
    end else begin
      tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
    end
  end

  assign o_spi_so    = tx_sh_reg[7];
  // float at release
  // released the moment select rises, even mid byte
  assign o_spi_so_oe = oe_reg & ~i_spi_cs_n;
endmodule : osp_link

// ### sim/osp_top_chk.sv
// concurrent checks on the security page block ports
`timescale 1ns/100ps
module osp_top_chk
  import osp_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYC
) (
  input wire logic       i_sys_clk,
  input wire logic       i_rst,
  input wire logic       i_spi_sck,
  input wire logic       i_spi_cs_n,
  input wire logic       i_spi_si,
  input wire logic [2:0] i_lock_set,
  input wire logic       o_spi_so,
  input wire logic       o_spi_so_oe,
  input wire logic       o_ready_busy_flag,
  input wire logic       o_write_enable_latch,
  input wire logic [2:0] o_page_lock_bits
);
  int         busy_cnt_reg;
  logic [2:0] want_reg;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  // busy length and every lock ever requested, kept for the checks below
  always_ff @(posedge i_sys_clk) begin
    busy_cnt_reg <= (i_rst || !o_ready_busy_flag) ? 0 : busy_cnt_reg + 1;
    want_reg     <= i_rst ? 3'h0 : (want_reg | i_lock_set);
  end

  chk_busy_len: assert property ($fell(o_ready_busy_flag) |-> busy_cnt_reg == PROG_CYCLES)
    else $error("busy length wrong");
  chk_busy_bound: assert property (busy_cnt_reg <= PROG_CYCLES)
    else $error("busy too long");
  chk_start_release: assert property ($rose(o_ready_busy_flag) |-> i_spi_cs_n)
    else $error("busy rose with select low");
  chk_start_wen: assert property ($rose(o_ready_busy_flag) |-> o_write_enable_latch)
    else $error("operation without write enable");
  chk_end_wen: assert property (
    $fell(o_ready_busy_flag) |-> ##[0:2] !o_write_enable_latch)
    else $error("write enable kept after operation");
  chk_wen_release: assert property ($rose(o_write_enable_latch) |-> i_spi_cs_n)
    else $error("write enable set inside frame");
  chk_lock_keep: assert property (
    (o_page_lock_bits & $past(o_page_lock_bits)) == $past(o_page_lock_bits))
    else $error("lock bit cleared");
  chk_lock_take: assert property (
    (o_page_lock_bits & $past(want_reg, 2)) == $past(want_reg, 2))
    else $error("lock request not taken");
  chk_oe_select: assert property (i_spi_cs_n |-> !o_spi_so_oe)
    else $error("output driven while deselected");
  chk_oe_busy: assert property (o_ready_busy_flag |-> !o_spi_so_oe)
    else $error("output driven while busy");

  cov_busy: cover property ($fell(o_ready_busy_flag));
  cov_read: cover property ($rose(o_spi_so_oe));
  cov_lock: cover property ($rose(o_page_lock_bits[1]));
endmodule : osp_top_chk

bind osp_top osp_top_chk #(.PROG_CYCLES(PROG_CYCLES)) u_osp_top_chk (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_spi_sck(i_spi_sck), .i_spi_cs_n(i_spi_cs_n),
  .i_spi_si(i_spi_si), .i_lock_set(i_lock_set), .o_spi_so(o_spi_so),
  .o_spi_so_oe(o_spi_so_oe), .o_ready_busy_flag(o_ready_busy_flag),
  .o_write_enable_latch(o_write_enable_latch), .o_page_lock_bits(o_page_lock_bits));

// ### sim/osp_host.sv
// spi host model, mode 0, clock runs only inside frames
`timescale 1ns/100ps
module osp_host (
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_si,
  input  wire logic i_so,
  input  wire logic i_so_oe
);
  // idle bus: deselected, clock low
  initial begin
    o_sck  = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b0;
  end

  task automatic open_frame();
    o_cs_n = 1'b0;
    #4;
  endtask : open_frame

  // msb first; data sampled at the rising edge, undriven line reads unknown
  task automatic shift(input logic [7:0] b, input int nbits, output logic [7:0] r);
    r = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      o_si = b[i];
      #3 o_sck = 1'b1;
      r[i] = i_so_oe ? i_so : 1'bx;
      #3 o_sck = 1'b0;
    end
    o_si = ~o_si;
  endtask : shift

  // release one period after the last bit, then keep the 40 ns gap
  task automatic close_frame();
    #6 o_cs_n = 1'b1;
    #40;
  endtask : close_frame
endmodule : osp_host

// ### sim/osp_top_test.sv
// self-checking bench for the security page block
`timescale 1ns/100ps
module osp_top_test;
  import osp_pkg::*;
  localparam int          PROG = 300;
  localparam logic [63:0] UID  = 64'h5a3c_96e1_0f72_b4d8;  // arbitrary value
  logic       sys_clk, rst, sck, cs_n, si, so, so_oe, busy, wen;
  logic [2:0] lock_set, locks;
  logic [7:0] rxq[$];
  int         bad_count, checks_done, busy_cyc;

  osp_top #(.PROG_CYCLES(PROG), .UID_VALUE(UID)) u_osp_top (
    .i_sys_clk(sys_clk), .i_rst(rst), .i_spi_sck(sck), .i_spi_cs_n(cs_n), .i_spi_si(si),
    .i_lock_set(lock_set), .o_spi_so(so), .o_spi_so_oe(so_oe), .o_ready_busy_flag(busy),
    .o_write_enable_latch(wen), .o_page_lock_bits(locks));
  osp_host u_osp_host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so), .i_so_oe(so_oe));

  // 125 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // busy cycle count, cleared by each settle
  always @(posedge sys_clk) if (busy === 1'b1) busy_cyc++;

  task automatic check_bit(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : check_bit
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_val

  // one whole frame, last byte may be cut short
  task automatic frame(input logic [7:0] tx[$], input int last_bits = 8);
    logic [7:0] r;
    rxq = {};
    u_osp_host.open_frame();
    foreach (tx[i]) begin
      u_osp_host.shift(tx[i], (i == tx.size() - 1) ? last_bits : 8, r);
      rxq.push_back(r);
    end
    u_osp_host.close_frame();
  endtask : frame
  // bounded wait for idle, then the busy length and latch state
  task automatic settle(input int exp_cyc);
    int k;
    k = 0;
    repeat (8) @(negedge sys_clk);
    while (busy === 1'b1 && k < 1000) begin
      @(negedge sys_clk);
      k++;
    end
    check_val(busy_cyc[15:0], exp_cyc[15:0], "busy cycles");
    check_bit(wen, 1'b0, "latch after op");
    busy_cyc = 0;
  endtask : settle
  task automatic wren();
    frame('{OP_WREN});
    repeat (2) @(negedge sys_clk);
    check_bit(wen, 1'b1, "latch set");
  endtask : wren

  task automatic t_reset();
    check_bit(busy, 1'b0, "reset busy");
    check_bit(wen, LATCH_RST, "reset latch");
    check_val({13'h0000, locks}, {13'h0000, LOCK_RST}, "reset locks");
  endtask : t_reset
  task automatic t_uid();
    frame('{OP_UID, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00, 8'h00});
    for (int i = 0; i < 8; i++) check_val(rxq[5 + i], UID[63 - 8 * i -: 8], "id byte");
    check_bit(rxq[4][0], 1'bx, "no data in dummy");
  endtask : t_uid
  task automatic t_erase_all();
    frame('{OP_ERASE, 8'h00, 8'h10, 8'h00});
    settle(0);
    for (int p = 1; p <= 3; p++) begin
      wren();
      frame('{OP_ERASE, 8'h00, 8'(p << 4), 8'h5a});
      settle(PROG);
    end
  endtask : t_erase_all
  task automatic t_prog_read();
    wren();
    frame('{OP_PROG, 8'h00, 8'h10, 8'hfe, 8'h12, 8'h34, 8'h56});
    frame('{OP_READ, 8'h00, 8'h10, 8'hfe, 8'h00, 8'h00});
    check_bit(rxq[5][7], 1'bx, "read while busy");
    settle(PROG);
    frame('{OP_READ, 8'h00, 8'h10, 8'hfe, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    check_val(rxq[5], 8'h12, "read start");
    check_val(rxq[6], 8'h34, "read next");
    check_val(rxq[7], 8'h56, "read wrapped");
    check_val(rxq[8], ERASED_BYTE, "read past");
    frame('{OP_READ, 8'h00, 8'h20, 8'hfe, 8'h00, 8'h00});
    check_val(rxq[5], ERASED_BYTE, "other page");
  endtask : t_prog_read
  task automatic t_aborts();
    wren();
    frame('{OP_ERASE, 8'h00, 8'h20});
    settle(0);
    wren();
    frame('{OP_ERASE, 8'h00, 8'h20, 8'h00}, 7);
    settle(0);
    frame('{OP_WREN, 8'h00}, 5);
    repeat (2) @(negedge sys_clk);
    check_bit(wen, 1'b0, "cut enable ignored");
    wren();
    frame('{OP_WRDI});
    frame('{OP_ERASE, 8'h00, 8'h10, 8'h00});
    settle(0);
    frame('{OP_READ, 8'h00, 8'h10, 8'hff, 8'h00, 8'h00}, 3);
    check_val(rxq[5], 8'h20, "partial byte");
    check_bit(so_oe, 1'b0, "released output");
  endtask : t_aborts
  task automatic t_locks();
    @(negedge sys_clk) lock_set = 3'h2;
    @(negedge sys_clk) lock_set = 3'h0;
    repeat (4) @(negedge sys_clk);
    check_val({13'h0000, locks}, 16'h0002, "lock set");
    wren();
    frame('{OP_ERASE, 8'h00, 8'h20, 8'h00});
    settle(0);
    wren();
    frame('{OP_PROG, 8'h00, 8'h20, 8'h00, 8'h00});
    settle(0);
  endtask : t_locks

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  // watchdog well beyond the roughly 16 us the sequence needs
  initial begin
    #400_000;
    bad_count++;
    close_out();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    lock_set = 3'h0;
    bad_count = 0;
    checks_done = 0;
    busy_cyc = 0;
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    t_reset();
    t_uid();
    t_erase_all();
    t_prog_read();
    t_aborts();
    t_locks();
    close_out();
  end
endmodule : osp_top_test
